// ### hw/timebase_rtc_control.sv
// Timebase divider, clock counters, stopwatch and event flags
`timescale 1ns/1ns
module timebase_rtc_control (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        xtal_tick,
  input  wire logic [15:0] bus_addr,
  input  wire logic [7:0]  bus_wdata,
  input  wire logic        bus_wr,
  input  wire logic        bus_rd,
  output logic      [7:0]  bus_rdata,
  output logic             rtc_irq,
  output logic             display_tick,
  output logic             watchdog_reset
);

  // ===========================================================
  // Reset release
  logic [1:0] rst_sync_q;
  logic       rst_ok;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) rst_sync_q <= 2'h0;
    else rst_sync_q <= {rst_sync_q[0], 1'b1};
  end

  assign rst_ok = rst_sync_q[1];

  // ===========================================================
  // State
  typedef struct packed {
    logic        xt;
    logic        locked;
    logic        run;
    logic        tb_clr;
    logic        swclr;
    logic [1:0]  crs;
    logic        halve;
    logic        xopt;
    logic [7:0]  ctrl;
    logic        half_ph;
    logic [8:0]  pre;
    logic [4:0]  div4;
    logic        div2;
    logic        div1;
    logic [3:0]  div10;
    logic [7:0]  sw;
    logic [5:0]  sec;
    logic [5:0]  min;
    logic [4:0]  hr;
    logic [5:0]  al_min;
    logic [4:0]  al_hr;
    logic        match;
    logic [5:0]  flags;
    logic [5:0]  armed;
    logic [7:0]  rdata;
    logic        irq;
    logic        disp;
  } rtc_state_t;

  rtc_state_t s_q;
  rtc_state_t s_d;

  // ===========================================================
  // Helpers
  function automatic logic [15:0] flag_reg(input int idx);
    unique case (idx)
      rtc_pkg::F_PER:  flag_reg = rtc_pkg::IRQ_CTRL_ADDR;
      rtc_pkg::F_HOUR: flag_reg = rtc_pkg::HOUR_ADDR;
      rtc_pkg::F_MIN:  flag_reg = rtc_pkg::MIN_ADDR;
      rtc_pkg::F_SEC:  flag_reg = rtc_pkg::SEC_ADDR;
      rtc_pkg::F_AL:   flag_reg = rtc_pkg::AL_MIN_ADDR;
      default:         flag_reg = rtc_pkg::SW_COUNT_ADDR;
    endcase
  endfunction : flag_reg

  function automatic logic hit(input logic [15:0] a,
                               input logic [15:0] r);
    hit = (a == r);
  endfunction : hit

  // ===========================================================
  // Events
  logic       wr_tb;
  logic       base;
  logic       t100;
  logic       t4;
  logic       t2;
  logic       t1;
  logic       t10;
  logic       per_ev;
  logic       match_now;
  logic [8:0] pre_last;
  logic [5:0] en_vec;
  logic [5:0] set_vec;
  logic       wd_tmo;

  always_comb begin
    wr_tb = bus_wr && hit(bus_addr, rtc_pkg::TB_CTRL_ADDR);
    // Crystal events only act from the registered copy
    base = s_q.xt && (!s_q.halve || s_q.half_ph);
    // Default option 0 selects the 38400 Hz ratio
    pre_last = s_q.xopt ? rtc_pkg::DIV100_32K - 9'h001
                        : rtc_pkg::DIV100_38K - 9'h001;
    t100 = base && (s_q.pre == pre_last);
    // 100 Hz / 25 gives 4 Hz, well inside the 5 to 3.3 Hz band
    t4 = t100 && (s_q.div4 == rtc_pkg::DIV_4HZ - 5'h01);
    t2 = t4 && s_q.div2;
    t1 = t2 && s_q.div1;
    t10 = t100 && (s_q.div10 == rtc_pkg::DIV_10HZ - 4'h1);
    unique case (s_q.ctrl[1:0])
      2'h0: per_ev = 1'b0;
      2'h1: per_ev = t1;
      2'h2: per_ev = t2;
      2'h3: per_ev = t4;
    endcase
    match_now = (s_q.hr == s_q.al_hr) && (s_q.min == s_q.al_min);
    en_vec = '0;
    en_vec[rtc_pkg::F_PER]  = |s_q.ctrl[1:0];
    en_vec[rtc_pkg::F_HOUR] = s_q.ctrl[rtc_pkg::IC_HOUR];
    en_vec[rtc_pkg::F_MIN]  = s_q.ctrl[rtc_pkg::IC_MIN];
    en_vec[rtc_pkg::F_SEC]  = s_q.ctrl[rtc_pkg::IC_SEC];
    en_vec[rtc_pkg::F_AL]   = s_q.ctrl[rtc_pkg::IC_ALIE];
    en_vec[rtc_pkg::F_SW]   = s_q.ctrl[rtc_pkg::IC_SWIE];
  end

  // ===========================================================
  // Next state
  always_comb begin
    s_d = s_q;
    set_vec = '0;
    s_d.xt = xtal_tick;
    s_d.disp = 1'b0;

    // Timebase chain
    if (s_q.xt) s_d.half_ph = ~s_q.half_ph;
    if (base) begin
      s_d.pre = (s_q.pre == pre_last) ? 9'h000 : s_q.pre + 9'h001;
    end
    if (t100) begin
      s_d.disp = 1'b1;
      s_d.div4 = (s_q.div4 == rtc_pkg::DIV_4HZ - 5'h01)
               ? 5'h00 : s_q.div4 + 5'h01;
      s_d.div10 = (s_q.div10 == rtc_pkg::DIV_10HZ - 4'h1)
                ? 4'h0 : s_q.div10 + 4'h1;
    end
    if (t4) s_d.div2 = ~s_q.div2;
    if (t2) s_d.div1 = ~s_q.div1;
    if (per_ev) set_vec[rtc_pkg::F_PER] = 1'b1;

    // Time of day
    if (s_q.run && t1) begin
      set_vec[rtc_pkg::F_SEC] = 1'b1;
      if (s_q.sec == rtc_pkg::LAST_SEC) begin
        s_d.sec = 6'h00;
        set_vec[rtc_pkg::F_MIN] = 1'b1;
        if (s_q.min == rtc_pkg::LAST_SEC) begin
          s_d.min = 6'h00;
          set_vec[rtc_pkg::F_HOUR] = 1'b1;
          s_d.hr = (s_q.hr == rtc_pkg::LAST_HOUR)
                 ? 5'h00 : s_q.hr + 5'h01;
        end else begin
          s_d.min = s_q.min + 6'h01;
        end
      end else begin
        s_d.sec = s_q.sec + 6'h01;
      end
    end

    // Alarm fires on the first cycle of a match while the clock runs;
    // reset leaves both times at zero, already matched before the clock can run, so no alarm fires
    s_d.match = match_now;
    if (s_q.run && match_now && !s_q.match)
      set_vec[rtc_pkg::F_AL] = 1'b1;

    // Stopwatch
    if (s_q.swclr) begin
      s_d.sw = 8'h00;
    end else if (t100 && s_q.ctrl[rtc_pkg::IC_SWCE]) begin
      s_d.sw = s_q.sw + 8'h01;
    end
    if (t10 && s_q.ctrl[rtc_pkg::IC_SWCE])
      set_vec[rtc_pkg::F_SW] = 1'b1;

    // Timebase clear is applied one cycle after the write
    if (s_q.tb_clr) begin
      s_d.half_ph = 1'b0;
      s_d.pre = '0;
      s_d.div4 = '0;
      s_d.div2 = 1'b0;
      s_d.div1 = 1'b0;
      s_d.div10 = '0;
      s_d.disp = 1'b0;
    end
    s_d.tb_clr = 1'b0;

    // Register writes
    if (bus_wr) begin
      unique case (bus_addr)
        rtc_pkg::TB_CTRL_ADDR: begin
          s_d.run = bus_wdata[rtc_pkg::TB_RUN];
          s_d.tb_clr = bus_wdata[rtc_pkg::TB_CLR];
          s_d.swclr = bus_wdata[rtc_pkg::TB_SWCLR];
          // A bit set or clear arrives as a full write, so locks too
          if (!s_q.locked) begin
            s_d.crs = bus_wdata[rtc_pkg::TB_CRS +: 2];
            s_d.halve = bus_wdata[rtc_pkg::TB_HALVE];
            s_d.xopt = bus_wdata[rtc_pkg::TB_XOPT];
            s_d.locked = 1'b1;
          end
        end
        rtc_pkg::IRQ_CTRL_ADDR: s_d.ctrl = bus_wdata;
        rtc_pkg::SEC_ADDR:      s_d.sec = bus_wdata[5:0];
        rtc_pkg::MIN_ADDR:      s_d.min = bus_wdata[5:0];
        rtc_pkg::HOUR_ADDR:     s_d.hr = bus_wdata[4:0];
        rtc_pkg::AL_MIN_ADDR:   s_d.al_min = bus_wdata[5:0];
        rtc_pkg::AL_HOUR_ADDR:  s_d.al_hr = bus_wdata[4:0];
        default: ;
      endcase
    end

    // Reads: data, then two-step flag clearing
    if (bus_rd) begin
      unique case (bus_addr)
        rtc_pkg::TB_CTRL_ADDR:
          s_d.rdata = {s_q.run, 1'b0, s_q.swclr, s_q.crs, 1'b0,
                       s_q.halve, s_q.xopt};
        rtc_pkg::IRQ_CTRL_ADDR: s_d.rdata = s_q.ctrl;
        rtc_pkg::FLAGS_ADDR:    s_d.rdata = {2'h0, s_q.flags};
        rtc_pkg::SW_COUNT_ADDR: s_d.rdata = s_q.sw;
        rtc_pkg::SEC_ADDR:      s_d.rdata = {2'h0, s_q.sec};
        rtc_pkg::MIN_ADDR:      s_d.rdata = {2'h0, s_q.min};
        rtc_pkg::HOUR_ADDR:     s_d.rdata = {3'h0, s_q.hr};
        rtc_pkg::AL_MIN_ADDR:   s_d.rdata = {2'h0, s_q.al_min};
        rtc_pkg::AL_HOUR_ADDR:  s_d.rdata = {3'h0, s_q.al_hr};
        default:                s_d.rdata = rtc_pkg::REG_RESET;
      endcase
      for (int i = 0; i < rtc_pkg::NFLAGS; i++) begin
        if (s_q.armed[i] && hit(bus_addr, flag_reg(i))) begin
          s_d.flags[i] = 1'b0;
          s_d.armed[i] = 1'b0;
        end
      end
      if (hit(bus_addr, rtc_pkg::FLAGS_ADDR))
        s_d.armed = s_q.armed | s_q.flags;
    end

    // A new event beats a clear in the same cycle
    s_d.flags = s_d.flags | set_vec;
    s_d.armed = s_d.armed & ~set_vec;

    s_d.irq = |(s_q.flags & en_vec);
  end

  always_ff @(posedge sys_clk or negedge rst_ok) begin
    if (!rst_ok) s_q <= '0;
    else s_q <= s_d;
  end

  // ===========================================================
  // Watchdog
  rtc_watchdog u_watchdog (
    .sys_clk   (sys_clk),
    .rst_n     (rst_ok),
    .xtal_en   (base),
    .tb_clear  (s_q.tb_clr),
    .refresh   (bus_wr && hit(bus_addr, rtc_pkg::WD_REFRESH_ADDR)),
    .rate      (s_q.crs),
    .timeout_q (wd_tmo)
  );

  assign bus_rdata      = s_q.rdata;
  assign rtc_irq        = s_q.irq;
  assign display_tick   = s_q.disp;
  assign watchdog_reset = wd_tmo;

  // ===========================================================
  // Checks
  chk_clear_reads_zero: assert property (
    @(posedge sys_clk) disable iff (!rst_ok)
    bus_rd && bus_addr == rtc_pkg::TB_CTRL_ADDR
    |=> !bus_rdata[rtc_pkg::TB_CLR])
    else $error("timebase clear bit read back as one");

  chk_clear_self: assert property (
    @(posedge sys_clk) disable iff (!rst_ok)
    s_q.tb_clr && !wr_tb |=> !s_q.tb_clr)
    else $error("timebase clear bit did not self-clear");

  chk_clear_chain: assert property (
    @(posedge sys_clk) disable iff (!rst_ok)
    s_q.tb_clr |=> s_q.pre == '0 && s_q.div4 == '0)
    else $error("timebase chain not cleared");

  chk_rtc_hold: assert property (
    @(posedge sys_clk) disable iff (!rst_ok)
    !s_q.run && !bus_wr |=> $stable(s_q.sec))
    else $error("seconds moved while clock disabled");

  chk_time_range: assert property (
    @(posedge sys_clk) disable iff (!rst_ok)
    s_q.sec <= rtc_pkg::LAST_SEC && s_q.min <= rtc_pkg::LAST_SEC)
    else $error("seconds or minutes out of range");

  chk_hour_range: assert property (
    @(posedge sys_clk) disable iff (!rst_ok)
    s_q.hr <= rtc_pkg::LAST_HOUR)
    else $error("hours out of range");

  chk_sw_clear: assert property (
    @(posedge sys_clk) disable iff (!rst_ok)
    s_q.swclr ##1 s_q.swclr |-> s_q.sw == 8'h00)
    else $error("stopwatch not held at zero");

  chk_sw_gate: assert property (
    @(posedge sys_clk) disable iff (!rst_ok)
    !s_q.ctrl[rtc_pkg::IC_SWCE] && !s_q.swclr |=> $stable(s_q.sw))
    else $error("stopwatch counted while gated");

  chk_rate_lock: assert property (
    @(posedge sys_clk) disable iff (!rst_ok)
    s_q.locked |=> $stable(s_q.crs) && $stable(s_q.xopt))
    else $error("write-once field changed after lock");

  chk_irq_or: assert property (
    @(posedge sys_clk) disable iff (!rst_ok)
    |(s_q.flags & en_vec) |=> rtc_irq)
    else $error("enabled flag raised no interrupt");

endmodule : timebase_rtc_control

// ### common/rtc_pkg.sv
// Constants for the timebase and real-time clock control block
// Operation
// - Time counters run only while rtc enabled
// - Timebase clear self-clears, always reads zero
// - Timebase clear restarts every derived clock
// - Stopwatch clear forces and holds count zero
// - Watchdog rate accepted on first write only
// - Unwritten watchdog rate stays at 00
// - Watchdog rate selects 1,2,4,8 second spans
// - Any control write counts as first write
// - Refresh shortens timeout by low-stage phase
// - Halve bit adds divide-by-two, first write
// - Crystal option picks ratios, first write
// - Option 0 is 38400 Hz, 1 32000
// - Timebase starts as 38400 Hz until written
// - Hour, minute, second flags gated by enables
// - Stopwatch and alarm flags gated by enables
// - Stopwatch clock enable gates 100 Hz tick
// - Periodic select: off, 1, 2, 4 Hz
// - 4 Hz periodic intervals stay within 5-3.3 Hz
// - Flag clears after status then data read
// - Seconds, minutes wrap after 59, carry on
// - Hours advance on minute wrap, wrap after 23
// - Alarm flag on hours and minutes match
package rtc_pkg;

  // ===========================================================
  // Register offsets
  localparam logic [15:0] TB_CTRL_ADDR  = 16'h0035;
  localparam logic [15:0] IRQ_CTRL_ADDR = 16'h0036;
  localparam logic [15:0] FLAGS_ADDR    = 16'h0037;
  localparam logic [15:0] SW_COUNT_ADDR = 16'h0038;
  localparam logic [15:0] SEC_ADDR      = 16'h0039;
  localparam logic [15:0] MIN_ADDR      = 16'h003A;
  localparam logic [15:0] HOUR_ADDR     = 16'h003B;
  localparam logic [15:0] AL_MIN_ADDR   = 16'h003C;
  localparam logic [15:0] AL_HOUR_ADDR  = 16'h003D;
  localparam logic [15:0] WD_REFRESH_ADDR = 16'hFFFF;

  // ===========================================================
  // Timebase control bit positions
  localparam int TB_RUN   = 7;
  localparam int TB_CLR   = 6;
  localparam int TB_SWCLR = 5;
  localparam int TB_CRS   = 3;
  localparam int TB_HALVE = 1;
  localparam int TB_XOPT  = 0;

  // Interrupt control bit positions
  localparam int IC_HOUR  = 7;
  localparam int IC_MIN   = 6;
  localparam int IC_SEC   = 5;
  localparam int IC_SWIE  = 4;
  localparam int IC_SWCE  = 3;
  localparam int IC_ALIE  = 2;

  // Flag positions, shared by the flag register
  localparam int F_PER  = 5;
  localparam int F_HOUR = 4;
  localparam int F_MIN  = 3;
  localparam int F_SEC  = 2;
  localparam int F_AL   = 1;
  localparam int F_SW   = 0;
  localparam int NFLAGS = 6;

  localparam logic [7:0] REG_RESET = 8'h00;

  // ===========================================================
  // Division counts
  localparam logic [8:0] DIV100_38K = 9'h180;
  localparam logic [8:0] DIV100_32K = 9'h140;
  localparam logic [4:0] DIV_4HZ    = 5'h19;
  localparam logic [3:0] DIV_10HZ   = 4'hA;
  localparam logic [5:0] LAST_SEC   = 6'h3B;
  localparam logic [4:0] LAST_HOUR  = 5'h17;
  localparam int WD_PRE_BITS  = 8;
  localparam int WD_BASE_BITS = 7;

endpackage : rtc_pkg

// ### hw/rtc_watchdog.sv
// Watchdog counter chain fed by the timebase crystal tick
`timescale 1ns/1ns
module rtc_watchdog #(
  parameter int PRE_BITS  = rtc_pkg::WD_PRE_BITS,
  parameter int BASE_BITS = rtc_pkg::WD_BASE_BITS
) (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       xtal_en,
  input  wire logic       tb_clear,
  input  wire logic       refresh,
  input  wire logic [1:0] rate,
  output logic            timeout_q
);

  localparam int MB = BASE_BITS + 3;

  if (PRE_BITS < 1 || BASE_BITS < 1) begin : g_bad_width
    $error("watchdog stage widths must be positive");
  end

  typedef struct packed {
    logic [PRE_BITS-1:0] pre;
    logic [MB-1:0]       cnt;
    logic                tmo;
  } wd_state_t;

  wd_state_t s_q;
  wd_state_t s_d;
  logic [MB-1:0] last;

  always_comb begin
    // 2^(base+rate) low-stage wraps: 1, 2, 4, 8 s at 32 kHz
    last = MB'((1 << (BASE_BITS + 32'(rate))) - 1);
    s_d = s_q;
    s_d.tmo = 1'b0;
    if (xtal_en) begin
      s_d.pre = s_q.pre + 1'b1;
      if (&s_q.pre) begin
        if (s_q.cnt == last) begin
          s_d.cnt = '0;
          s_d.tmo = 1'b1;
        end else begin
          s_d.cnt = s_q.cnt + 1'b1;
        end
      end
    end
    // Low stage keeps its phase: each refresh loses up to 255 ticks
    // A refresh in the same cycle as the timeout still saves the system
    if (refresh) begin
      s_d.cnt = '0;
      s_d.tmo = 1'b0;
    end
    if (tb_clear) begin
      s_d.pre = '0;
      s_d.cnt = '0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) s_q <= '0;
    else s_q <= s_d;
  end

  assign timeout_q = s_q.tmo;

  chk_refresh_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
    refresh && !tb_clear |=> s_q.cnt == '0 && !timeout_q)
    else $error("refresh did not restart the watchdog");

endmodule : rtc_watchdog

// ### test/xtal_src.sv
// Crystal tick source standing in for the oscillator
`timescale 1ns/1ns
module xtal_src #(
  parameter int DIV = 1
) (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  output logic      xtal_tick
);
  int cnt_q;

  // ==========================================================
  // Tick generator
  // DIV of 1 keeps the line high, the fastest legal crystal rate
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q     <= 0;
      xtal_tick <= 1'b0;
    end else begin
      cnt_q     <= (cnt_q == DIV - 1) ? 0 : cnt_q + 1;
      xtal_tick <= (cnt_q == DIV - 1);
    end
  end
endmodule : xtal_src

// ### test/tb.sv
// Self-checking bench for the timebase and clock control block
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fails++; \
  $display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end
module tb;
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        xtal_tick;
  logic [15:0] bus_addr = 16'h0000;
  logic [7:0]  bus_wdata = 8'h00;
  logic        bus_wr = 1'b0;
  logic        bus_rd = 1'b0;
  logic [7:0]  bus_rdata;
  logic        rtc_irq;
  logic        display_tick;
  logic        watchdog_reset;
  logic [31:0] seed = 32'h73FD;
  logic [7:0]  v;
  logic [7:0]  r;
  logic [7:0]  hr;
  logic [7:0]  mn;
  logic        ok;
  int          fails = 0;
  int          n_checks = 0;
  int          n_wd = 0;
  int          n;
  int          exp;
  int          cyc = 0;
  int          t0 = 0;
  int          t_wd = 0;

  xtal_src #(.DIV(1)) xsrc (.sys_clk(sys_clk), .rst_n(rst_n),
                            .xtal_tick(xtal_tick));
  timebase_rtc_control dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .xtal_tick(xtal_tick),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_rdata(bus_rdata), .rtc_irq(rtc_irq),
    .display_tick(display_tick), .watchdog_reset(watchdog_reset));

  always #20 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc++;
    if (watchdog_reset === 1'b1) begin
      n_wd++;
      t_wd = cyc;
    end
  end

  // ==========================================================
  // Helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h0400_0007 : 32'h0);
  endfunction : lfsr

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk) #1;
    bus_addr  = a;
    bus_wdata = d;
    bus_wr    = 1'b1;
    @(posedge sys_clk) #1;
    bus_wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge sys_clk) #1;
    bus_addr = a;
    bus_rd   = 1'b1;
    @(posedge sys_clk) #1;
    bus_rd = 1'b0;
    d = bus_rdata;
  endtask : rd

  task automatic rdc(input logic [15:0] a, input logic [7:0] e,
                     input string nm);
    logic [7:0] d;
    rd(a, d);
    `CHK(nm, e, d)
  endtask : rdc

  // Flags are read first so every following data read clears its flag
  task automatic clr_flags;
    logic [15:0] al [7] = '{16'h0037, 16'h0036, 16'h003B, 16'h003A,
                            16'h0039, 16'h003C, 16'h0038};
    foreach (al[i]) rd(al[i], r);
  endtask : clr_flags

  // Mode 0 waits for the display tick, 1 for the irq level with a
  // watchdog refresh every 4096 cycles, 2 for the irq level alone;
  // pulses are never waited on with refreshes, which could hide one
  task automatic wait_ev(input int md, input int lim, output int cnt);
    cnt = 0;
    do begin
      if (md == 1 && cnt % 4096 == 4095) begin
        wr(16'hFFFF, 8'h00);
        cnt += 2;
      end else begin
        @(posedge sys_clk) #1;
        cnt++;
      end
    end while (!(md != 0 ? rtc_irq : display_tick) && cnt < lim);
  endtask : wait_ev

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : give_verdict

  // ==========================================================
  // Tests
  initial begin
    #5200000;
    fails++;
    give_verdict;
  end

  initial begin
    repeat (2) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    repeat (3) @(posedge sys_clk);
    for (int a = 'h35; a <= 'h3D; a++) rdc(16'(a), 8'h00, "reset value");
    rdc(16'h0040, 8'h00, "unmapped read");
    wait_ev(0, 1000, n);
    wait_ev(0, 1000, n);
    `CHK("default tick period", 384, n)
    repeat (4) begin
      seed = lfsr(seed);
      v  = 8'(seed[7:0] % 60);
      mn = 8'(seed[23:16] % 60);
      hr = 8'(seed[15:8] % 24);
      wr(16'h0039, v);
      wr(16'h003A, mn);
      wr(16'h003B, hr);
      wr(16'h003D, hr);
      rdc(16'h0039, v, "seconds");
      rdc(16'h003A, mn, "minutes");
      rdc(16'h003B, hr, "hours");
      rdc(16'h003D, hr, "alarm hours");
    end
    $display("test reset and stopped counters done");

    wr(16'h0035, 8'h81);
    rdc(16'h0035, 8'h81, "first control write");
    wr(16'h0035, 8'hFF);
    rdc(16'h0035, 8'hA1, "locked fields");
    wr(16'h0035, 8'hC1);
    wait_ev(0, 1000, n);
    ok = n >= 318 && n <= 326;
    `CHK("tick after clear", 1'b1, ok)
    wait_ev(0, 1000, n);
    `CHK("tick period", 320, n)
    $display("test control write-once done");

    wr(16'h0035, 8'hC1);
    wr(16'h0039, 8'h3B);
    wr(16'h003A, 8'h3B);
    wr(16'h003B, 8'h17);
    wr(16'h003C, 8'h00);
    wr(16'h003D, 8'h00);
    wr(16'h0036, 8'h00);
    clr_flags;
    rdc(16'h0037, 8'h00, "flags cleared");
    `CHK("irq idle", 1'b0, rtc_irq)
    wr(16'h0036, 8'hE4);
    wait_ev(1, 34000, n);
    `CHK("irq at wrap", 1'b1, rtc_irq)
    rdc(16'h0039, 8'h00, "seconds wrap");
    rdc(16'h003A, 8'h00, "minutes wrap");
    rdc(16'h003B, 8'h00, "hours wrap");
    rdc(16'h0037, 8'h1E, "wrap flags");
    rd(16'h0039, r);
    rdc(16'h0037, 8'h1A, "second flag cleared");
    `CHK("irq held", 1'b1, rtc_irq)
    rd(16'h003B, r);
    rd(16'h003A, r);
    rd(16'h003C, r);
    rdc(16'h0037, 8'h00, "all cleared");
    `CHK("irq dropped", 1'b0, rtc_irq)
    $display("test rollover and flags done");

    wr(16'h0035, 8'hC1);
    wr(16'h0036, 8'h08);
    repeat (3500) @(posedge sys_clk);
    `CHK("stopwatch irq masked", 1'b0, rtc_irq)
    rdc(16'h0038, 8'h0A, "stopwatch count");
    rdc(16'h0037, 8'h01, "stopwatch flag kept");
    wr(16'h0036, 8'h18);
    repeat (2) @(posedge sys_clk);
    #1;
    `CHK("stopwatch irq", 1'b1, rtc_irq)
    rd(16'h0038, r);
    rdc(16'h0037, 8'h00, "stopwatch flag cleared");
    wr(16'h0035, 8'hA1);
    rdc(16'h0038, 8'h00, "stopwatch cleared");
    repeat (700) @(posedge sys_clk);
    rdc(16'h0038, 8'h00, "stopwatch held");
    wr(16'h0035, 8'h81);
    wr(16'h0036, 8'h00);
    $display("test stopwatch done");

    for (int c = 3; c >= 1; c--) begin
      clr_flags;
      wr(16'h0035, 8'hC1);
      t0 = cyc;
      wr(16'h0036, 8'(c));
      wait_ev(2, 40000, n);
      exp = 8000 << (3 - c);
      ok = n >= exp - 8 && n <= exp + 8;
      `CHK("periodic interval", 1'b1, ok)
      rdc(16'h0037, (c == 1) ? 8'h24 : 8'h20, "periodic flag");
      wr(16'h0036, 8'h00);
    end
    $display("test periodic rates done");
    `CHK("no watchdog reset", 0, n_wd)
    // The 1 Hz pass started on a timebase clear with no refresh since: it must expire
    n = 0;
    while (n_wd == 0 && n < 2000) begin
      @(posedge sys_clk) #1;
      n++;
    end
    exp = (1 << (rtc_pkg::WD_PRE_BITS + rtc_pkg::WD_BASE_BITS)) + 2;
    `CHK("watchdog timeout", exp, t_wd - t0)
    `CHK("watchdog pulse", 1'b0, watchdog_reset)
    $display("test watchdog timeout done");

    @(posedge sys_clk) #1 rst_n = 1'b0;
    repeat (2) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    repeat (3) @(posedge sys_clk);
    rdc(16'h0037, 8'h00, "no alarm after reset");
    wr(16'h0035, 8'h0A);
    rdc(16'h0035, 8'h0A, "halve first write");
    wait_ev(0, 2000, n);
    wait_ev(0, 2000, n);
    `CHK("halved tick period", 768, n)
    $display("test second reset done");
    give_verdict;
  end
endmodule : tb
